// ### common/efp_class_if.sv
// Decoded view of one operand, passed from the classifier to the result unit.
// Assumes one producer and one consumer per instance.
`timescale 1ns/1ps
interface efp_class_if;
  logic        sign;
  logic        zero;
  logic        inf;
  logic        nan;
  logic        den;
  logic [10:0] exp;
  logic [51:0] frac;
  modport src (output sign, zero, inf, nan, den, exp, frac);
  modport dst (input sign, zero, inf, nan, den, exp, frac);
endinterface

// ### common/efp_pkg.sv
// Constants, register map and helpers of the embedded float result unit.
// Assumes a single clock domain; operands arrive already aligned in 64 bits.
package efp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  // Control register fields.
  localparam int C_MODE = 0;
  localparam int C_RND = 1;
  localparam int C_INVE = 3;
  localparam int C_DBZE = 4;
  localparam int C_UNFE = 5;
  localparam int C_OVFE = 6;
  localparam int C_INXE = 7;
  localparam int C_EST = 8;
  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RST = 9'h000;
  // Sticky status fields.
  localparam int S_INX = 0;
  localparam int S_INV = 1;
  localparam int S_DBZ = 2;
  localparam int S_UNF = 3;
  localparam int S_OVF = 4;
  localparam int STK_W = 5;
  localparam logic [4:0] STK_RST = 5'h00;
  localparam logic [1:0] RND_NEG = 2'h3;
  localparam logic [1:0] OP_ADD = 2'h0;
  localparam logic [1:0] OP_SUB = 2'h1;
  localparam logic [1:0] OP_MUL = 2'h2;
  localparam logic [1:0] OP_DIV = 2'h3;
  localparam logic signed [13:0] EMAX_S = 14'sd254;
  localparam logic signed [13:0] EMAX_D = 14'sd2046;
  localparam logic signed [13:0] BIAS_S = 14'sd127;
  localparam logic signed [13:0] BIAS_D = 14'sd1023;
  localparam logic [10:0] EALL_S = 11'h0ff;
  localparam logic [10:0] EALL_D = 11'h7ff;

  function automatic logic signed [13:0] efp_emax(input logic dbl);
    return dbl ? EMAX_D : EMAX_S;
  endfunction

  function automatic logic [63:0] efp_pack(input logic dbl, input logic s,
                                           input logic [10:0] e, input logic [51:0] f);
    return dbl ? {s, e, f} : {32'h0000_0000, s, e[7:0], f[22:0]};
  endfunction

  function automatic logic [63:0] efp_sat(input logic dbl, input logic s);
    return efp_pack(dbl, s, 11'(efp_emax(dbl)), {52{1'b1}});
  endfunction

  function automatic logic efp_sign(input logic dbl, input logic [63:0] v);
    return dbl ? v[63] : v[31];
  endfunction

  function automatic logic [10:0] efp_exp(input logic dbl, input logic [63:0] v);
    return dbl ? v[62:52] : {3'h0, v[30:23]};
  endfunction
endpackage

// ### verif/efp_core_model.sv
// Model of the core pipeline that issues operations to the result stage.
// Assumes the bench calls issue from one process, clocked by the core clock.
`timescale 1ns/1ps
module efp_core_model (
  input  logic               clk,
  output logic               op_valid,
  output logic [1:0]         op_code,
  output logic               op_dbl,
  output logic [63:0]        op_a,
  output logic [63:0]        op_b,
  output logic signed [13:0] core_exp,
  output logic [51:0]        core_frac,
  output logic               core_zero,
  output logic               core_inexact
);
  initial begin
    op_valid = 1'h0;
    op_code = 2'h0;
    op_dbl = 1'h0;
    op_a = 64'h0;
    op_b = 64'h0;
    core_exp = 14'sh0;
    core_frac = 52'h0;
    core_zero = 1'h0;
    core_inexact = 1'h0;
  end

  // A gap of idle cycles before the issue lets the core be slow as well as prompt.
  task automatic issue(input int gap, input logic [1:0] code, input logic dbl, input logic [63:0] a,
                       input logic [63:0] b, input logic signed [13:0] e, input logic [51:0] f,
                       input logic z, input logic x);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    op_valid <= 1'h1;
    op_code <= code;
    op_dbl <= dbl;
    op_a <= a;
    op_b <= b;
    core_exp <= e;
    core_frac <= f;
    core_zero <= z;
    core_inexact <= x;
    @(posedge clk);
    op_valid <= 1'h0;
    // Idle operand, exponent and fraction lines carry inverted data, so stale values are never mistaken for an operation.
    op_a <= ~a;
    op_b <= ~b;
    core_exp <= ~e;
    core_frac <= ~f;
  endtask
endmodule

// ### verif/efp_result_tb_top.sv
// Self-checking bench of the result stage, with the core model as operand source.
// Assumes one 50 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
module efp_result_tb_top;
  import efp_pkg::*;
  localparam logic [63:0] ONE    = 64'h3f80_0000;
  localparam logic [63:0] BIG    = 64'h7f00_0000;
  localparam logic [63:0] PMAX   = 64'h7f7f_ffff;
  localparam logic [63:0] NMAX   = 64'hff7f_ffff;
  localparam logic [63:0] NZERO  = 64'h8000_0000;
  localparam logic [63:0] D_ONE  = 64'h3ff0_0000_0000_0000;
  localparam logic [63:0] D_PMAX = 64'h7fef_ffff_ffff_ffff;
  logic               clk       = 1'h0;
  logic               sys_rst   = 1'h1;
  logic [7:0]         reg_addr  = 8'h00;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_wr    = 1'h0;
  logic               reg_rd    = 1'h0;
  logic [31:0]        reg_rdata;
  logic               op_valid;
  logic [1:0]         op_code;
  logic               op_dbl;
  logic [63:0]        op_a;
  logic [63:0]        op_b;
  logic signed [13:0] core_exp;
  logic [51:0]        core_frac;
  logic               core_zero;
  logic               core_inexact;
  logic               res_valid;
  logic [63:0]        res_value;
  logic               res_ovf;
  logic               res_unf;
  logic               res_inexact;
  logic               data_irq;
  logic               round_irq;
  int                 errors    = 0;
  int                 cmp_count = 0;

  always #10 clk = ~clk;

  efp_core_model u_efp_core_model (.clk(clk), .op_valid(op_valid), .op_code(op_code), .op_dbl(op_dbl),
    .op_a(op_a), .op_b(op_b), .core_exp(core_exp), .core_frac(core_frac), .core_zero(core_zero),
    .core_inexact(core_inexact));

  efp_result u_efp_result (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid), .op_code(op_code),
    .op_dbl(op_dbl), .op_a(op_a), .op_b(op_b), .core_exp(core_exp), .core_frac(core_frac),
    .core_zero(core_zero), .core_inexact(core_inexact), .res_valid(res_valid), .res_value(res_value),
    .res_ovf(res_ovf), .res_unf(res_unf), .res_inexact(res_inexact), .data_irq(data_irq),
    .round_irq(round_irq));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk({32'h0, reg_rdata}, {32'h0, exp}, "register read");
  endtask

  // Flags are packed as overflow, underflow, inexact, data interrupt, round interrupt.
  task automatic run_op(input logic [1:0] code, input logic dbl, input logic [63:0] a, input logic [63:0] b,
                        input logic signed [13:0] e, input logic [51:0] f, input logic z, input logic x,
                        input logic [63:0] ev, input logic [4:0] ef);
    int n;
    n = 0;
    u_efp_core_model.issue(cmp_count % 3, code, dbl, a, b, e, f, z, x);
    #1;
    while (res_valid !== 1'h1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (res_valid !== 1'h1) begin
      errors++;
      $display("Error at %0t ns: no result", $time);
      complete_run();
    end else begin
      chk(res_value, ev, "result value");
      chk({59'h0, res_ovf, res_unf, res_inexact, data_irq, round_irq}, {59'h0, ef}, "result flags");
    end
  endtask

  task automatic sc_regs();
    reg_check(CTRL_OFS, 32'h0);
    reg_check(STAT_OFS, 32'h0);
    reg_write(CTRL_OFS, 32'h1ff);
    reg_check(CTRL_OFS, 32'h1fe);
    reg_write(8'h08, 32'hffff_ffff);
    reg_check(8'h08, 32'h0);
    reg_check(CTRL_OFS, 32'h1fe);
    reg_write(CTRL_OFS, 32'h0);
  endtask

  task automatic sc_limits();
    run_op(OP_ADD, 1'h0, ONE, ONE, 14'sd254, 52'h7f_ffff, 1'h0, 1'h0, PMAX, 5'h00);
    run_op(OP_MUL, 1'h0, ONE, ONE, 14'sd1, 52'h0, 1'h0, 1'h0, 64'h0080_0000, 5'h00);
    run_op(OP_ADD, 1'h0, BIG, ONE, 14'sd255, 52'h0, 1'h0, 1'h1, PMAX, 5'h14);
    run_op(OP_MUL, 1'h1, D_ONE, D_ONE, 14'sd2046, 52'h1, 1'h0, 1'h0, 64'h7fe0_0000_0000_0001, 5'h00);
    run_op(OP_ADD, 1'h1, D_ONE, D_ONE, 14'sd2047, 52'h0, 1'h0, 1'h0, D_PMAX, 5'h14);
    run_op(OP_MUL, 1'h1, {1'h1, D_ONE[62:0]}, D_ONE, 14'sd0, 52'h1, 1'h0, 1'h1, {1'h1, 63'h0}, 5'h0c);
    reg_check(STAT_OFS, 32'h19);
    run_op(OP_MUL, 1'h0, ONE, ONE, 14'sd127, 52'h0, 1'h0, 1'h0, ONE, 5'h00);
    reg_check(STAT_OFS, 32'h19);
    reg_write(STAT_OFS, 32'h0);
    reg_check(STAT_OFS, 32'h0);
  endtask

  task automatic sc_enables();
    reg_write(CTRL_OFS, 32'h40);
    run_op(OP_SUB, 1'h0, ONE, BIG, 14'sd255, 52'h0, 1'h0, 1'h0, NMAX, 5'h12);
    reg_write(CTRL_OFS, 32'h80);
    run_op(OP_ADD, 1'h0, ONE, ONE, 14'sd128, 52'h0, 1'h0, 1'h1, 64'h4000_0000, 5'h05);
    reg_write(CTRL_OFS, 32'h30);
    run_op(OP_DIV, 1'h0, ONE, NZERO, 14'sd0, 52'h0, 1'h0, 1'h0, NMAX, 5'h02);
    run_op(OP_MUL, 1'h0, 64'hbf80_0000, ONE, -14'sd5, 52'h1, 1'h0, 1'h0, NZERO, 5'h0a);
    reg_check(STAT_OFS, 32'h1d);
    reg_write(CTRL_OFS, 32'h08);
    run_op(OP_MUL, 1'h0, 64'h7f80_0000, ONE, 14'sd128, 52'h0, 1'h0, 1'h0, PMAX, 5'h02);
    reg_write(CTRL_OFS, 32'h0);
    reg_write(STAT_OFS, 32'h0);
  endtask

  task automatic sc_invalid();
    run_op(OP_MUL, 1'h0, 64'h7f80_0000, ONE, 14'sd128, 52'h0, 1'h0, 1'h0, PMAX, 5'h00);
    run_op(OP_MUL, 1'h0, 64'h7fc0_0000, 64'hbf80_0000, 14'sd128, 52'h0, 1'h0, 1'h0, NMAX, 5'h00);
    run_op(OP_ADD, 1'h1, 64'h7ff0_0000_0000_0000, D_ONE, 14'sd1024, 52'h0, 1'h0, 1'h0, D_PMAX, 5'h00);
    run_op(OP_MUL, 1'h1, 64'h1, D_ONE, 14'sd1023, 52'h0, 1'h0, 1'h0, 64'h0, 5'h00);
    run_op(OP_DIV, 1'h0, 64'h0, NZERO, 14'sd0, 52'h0, 1'h1, 1'h0, 64'h0, 5'h00);
    reg_check(STAT_OFS, 32'h02);
  endtask

  task automatic sc_signs();
    run_op(OP_ADD, 1'h0, NZERO, NZERO, 14'sd0, 52'h0, 1'h1, 1'h0, NZERO, 5'h00);
    run_op(OP_SUB, 1'h0, NZERO, 64'h0, 14'sd0, 52'h0, 1'h1, 1'h0, NZERO, 5'h00);
    run_op(OP_ADD, 1'h0, ONE, 64'hbf80_0000, 14'sd0, 52'h0, 1'h1, 1'h0, 64'h0, 5'h00);
    run_op(OP_ADD, 1'h0, 64'hc000_0000, ONE, 14'sd127, 52'h0, 1'h0, 1'h0, 64'hbf80_0000, 5'h00);
    reg_write(CTRL_OFS, 32'h06);
    run_op(OP_ADD, 1'h0, ONE, 64'hbf80_0000, 14'sd0, 52'h0, 1'h1, 1'h0, NZERO, 5'h00);
  endtask

  task automatic sc_estimate();
    reg_write(CTRL_OFS, 32'h100);
    run_op(OP_ADD, 1'h0, BIG, ONE, 14'sd200, 52'h0, 1'h0, 1'h0, PMAX, 5'h14);
    run_op(OP_MUL, 1'h0, BIG, ONE, 14'sd200, 52'h0, 1'h0, 1'h0, PMAX, 5'h14);
    run_op(OP_DIV, 1'h1, D_ONE, D_ONE, 14'sd1023, 52'h0, 1'h0, 1'h0, 64'h0, 5'h0c);
    reg_write(CTRL_OFS, 32'h0);
    run_op(OP_ADD, 1'h0, BIG, ONE, 14'sd200, 52'h0, 1'h0, 1'h0, 64'h6400_0000, 5'h00);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'h0;
    sc_regs();
    sc_limits();
    sc_enables();
    sc_invalid();
    sc_signs();
    sc_estimate();
    complete_run();
  end
endmodule

// ### verilog/efp_classify.sv
// Operand decoder for single and double words.
// Assumes a single word sits in the low 32 bits when dbl is low.
`timescale 1ns/1ps
module efp_classify (
  input  logic        dbl,
  input  logic [63:0] word,
  efp_class_if.src    cls
);
  import efp_pkg::*;
  logic fz;
  logic eall;

  always_comb begin
    cls.sign = efp_sign(dbl, word);
    cls.exp  = efp_exp(dbl, word);
    cls.frac = dbl ? word[51:0] : {29'h0, word[22:0]};
    fz       = (cls.frac == 52'h0);
    eall     = (cls.exp == (dbl ? EALL_D : EALL_S));
    cls.zero = (cls.exp == 11'h000) && fz;
    cls.inf  = eall && fz;
    cls.nan  = eall && !fz;
    cls.den  = (cls.exp == 11'h000) && !fz;
  end
endmodule

// ### verilog/efp_regs.sv
// Control and sticky status registers on a plain strobe port.
// Assumes one strobe per cycle; read data stand only in the cycle after the read.
`timescale 1ns/1ps
module efp_regs (
  input  logic                       clk,
  input  logic                       sys_rst,
  input  logic [efp_pkg::ADDR_W-1:0] reg_addr,
  input  logic [efp_pkg::DATA_W-1:0] reg_wdata,
  input  logic                       reg_wr,
  input  logic                       reg_rd,
  output logic [efp_pkg::DATA_W-1:0] reg_rdata,
  input  logic [efp_pkg::STK_W-1:0]  sticky_set,
  output logic [efp_pkg::CTRL_W-1:0] ctrl_reg
);
  import efp_pkg::*;
  logic [STK_W-1:0] sticky_reg;
  logic [STK_W-1:0] sticky_next;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (reg_wr && reg_addr == CTRL_OFS) begin
      // Only mode zero exists, so the mode bit stays zero.
      ctrl_reg <= {reg_wdata[CTRL_W-1:1], 1'b0};
    end
  end

  // A hardware set in the same cycle as a software clear wins.
  always_comb begin
    sticky_next = sticky_reg;
    if (reg_wr && reg_addr == STAT_OFS) begin
      sticky_next = reg_wdata[STK_W-1:0];
    end
    sticky_next = sticky_next | sticky_set;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sticky_reg <= STK_RST;
    end else begin
      sticky_reg <= sticky_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_addr == CTRL_OFS) begin
      reg_rdata <= {23'h0, ctrl_reg};
    end else if (reg_addr == STAT_OFS) begin
      reg_rdata <= {27'h0, sticky_reg};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  sticky_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(reg_wr && reg_addr == STAT_OFS) |=> ((sticky_reg & $past(sticky_reg)) == $past(sticky_reg)))
    else $error("sticky bit cleared by hardware");
  set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
    (sticky_set != 5'h00) |=> ((sticky_reg & $past(sticky_set)) == $past(sticky_set)))
    else $error("sticky set lost");
  rdata_window_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(reg_rd) |-> (reg_rdata == 32'h0000_0000))
    else $error("read data outside read window");
endmodule

// ### verilog/efp_result.sv
// Result and exception stage of the embedded floating-point unit.
// Assumes the core supplies operands with the raw rounded result of its arithmetic:
// an unbounded biased exponent, fraction, zero and inexact flags, one cycle per op.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module efp_result (
  input  logic                       clk,
  input  logic                       sys_rst,
  input  logic [efp_pkg::ADDR_W-1:0] reg_addr,
  input  logic [efp_pkg::DATA_W-1:0] reg_wdata,
  input  logic                       reg_wr,
  input  logic                       reg_rd,
  output logic [efp_pkg::DATA_W-1:0] reg_rdata,
  input  logic                       op_valid,
  input  logic [1:0]                 op_code,
  input  logic                       op_dbl,
  input  logic [63:0]                op_a,
  input  logic [63:0]                op_b,
  input  logic signed [13:0]         core_exp,
  input  logic [51:0]                core_frac,
  input  logic                       core_zero,
  input  logic                       core_inexact,
  output logic                       res_valid,
  output logic [63:0]                res_value,
  output logic                       res_ovf,
  output logic                       res_unf,
  output logic                       res_inexact,
  output logic                       data_irq,
  output logic                       round_irq
);
  import efp_pkg::*;

  efp_class_if ca();
  efp_class_if cb();

  logic [CTRL_W-1:0] ctrl;
  logic [STK_W-1:0]  sticky_set;
  logic              addsub;
  logic              sb_eff;
  logic              a_big;
  logic              r_sign;
  logic signed [13:0] ea;
  logic signed [13:0] eb;
  logic signed [13:0] emax;
  logic signed [13:0] bias;
  logic              bad_in;
  logic              big_in;
  logic              zz;
  logic              dbz;
  logic              invalid;
  logic              est_ovf;
  logic              est_unf;
  logic              ovf;
  logic              unf;
  logic              inexact;
  logic              data_c;
  logic              round_c;
  logic [63:0]       value;
  logic              dbl_reg;

  efp_classify u_cls_a (
    .dbl  (op_dbl),
    .word (op_a),
    .cls  (ca.src)
  );

  efp_classify u_cls_b (
    .dbl  (op_dbl),
    .word (op_b),
    .cls  (cb.src)
  );

  efp_regs u_regs (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .sticky_set (sticky_set),
    .ctrl_reg   (ctrl)
  );

  // Sign of the result.
  always_comb begin
    addsub = (op_code == OP_ADD) || (op_code == OP_SUB);
    sb_eff = cb.sign ^ (op_code == OP_SUB);
    a_big  = {ca.exp, ca.frac} >= {cb.exp, cb.frac};
    if (!addsub) begin
      r_sign = ca.sign ^ cb.sign;
    end else if (core_zero) begin
      r_sign = (ca.zero && ca.sign && cb.zero && sb_eff) || (ctrl[C_RND+:2] == RND_NEG);
    end else if (ca.sign == sb_eff) begin
      r_sign = ca.sign;
    end else begin
      r_sign = a_big ? ca.sign : sb_eff;
    end
  end

  // Exception detection with the enables as they stand at issue.
  always_comb begin
    ea      = {3'h0, ca.exp};
    eb      = {3'h0, cb.exp};
    emax    = efp_emax(op_dbl);
    bias    = op_dbl ? BIAS_D : BIAS_S;
    big_in  = ca.inf || ca.nan || cb.inf || cb.nan;
    bad_in  = big_in || ca.den || cb.den;
    zz      = (op_code == OP_DIV) && ca.zero && cb.zero;
    dbz     = (op_code == OP_DIV) && cb.zero && !ca.zero && !bad_in;
    invalid = bad_in || zz;
    est_ovf = ctrl[C_EST] && ((addsub && ((ea > eb ? ea : eb) == emax)) ||
              ((op_code == OP_MUL) && (ea + eb - bias == emax)));
    est_unf = ctrl[C_EST] && (op_code == OP_DIV) && (ea - eb - bias <= 14'sd1);
    ovf     = !invalid && !dbz && !core_zero && ((core_exp > emax) || est_ovf);
    unf     = !invalid && !dbz && !core_zero && !ovf &&
              ((core_exp < 14'sd1) || est_unf);
    inexact = !invalid && !dbz && (core_inexact ||
              (ovf && !ctrl[C_OVFE]) || (unf && !ctrl[C_UNFE]));
    data_c  = (invalid && ctrl[C_INVE]) || (dbz && ctrl[C_DBZE]) ||
              (ovf && ctrl[C_OVFE]) || (unf && ctrl[C_UNFE]);
    round_c = inexact && ctrl[C_INXE] && !data_c;
  end

  // Result selection; every path yields a normal value or a signed zero.
  always_comb begin
    if (invalid) begin
      value = big_in ? efp_sat(op_dbl, r_sign) : efp_pack(op_dbl, r_sign && !zz, 11'h0, 52'h0);
    end else if (dbz || ovf) begin
      value = efp_sat(op_dbl, r_sign);
    end else if (unf || core_zero) begin
      value = efp_pack(op_dbl, r_sign, 11'h0, 52'h0);
    end else begin
      value = efp_pack(op_dbl, r_sign, core_exp[10:0], core_frac);
    end
  end

  // Conditions go back to the sticky flags in the issuing cycle.
  always_comb begin
    sticky_set        = 5'h00;
    sticky_set[S_INX] = op_valid && inexact;
    sticky_set[S_INV] = op_valid && invalid;
    sticky_set[S_DBZ] = op_valid && dbz;
    sticky_set[S_UNF] = op_valid && unf;
    sticky_set[S_OVF] = op_valid && ovf;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      res_valid   <= 1'b0;
      res_value   <= 64'h0000_0000_0000_0000;
      res_ovf     <= 1'b0;
      res_unf     <= 1'b0;
      res_inexact <= 1'b0;
      dbl_reg     <= 1'b0;
    end else begin
      res_valid   <= op_valid;
      res_value   <= op_valid ? value : 64'h0000_0000_0000_0000;
      res_ovf     <= op_valid && ovf;
      res_unf     <= op_valid && unf;
      res_inexact <= op_valid && inexact;
      dbl_reg     <= op_dbl;
    end
  end

  // Interrupts are one-cycle pulses beside the result; data outranks round.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_irq  <= 1'b0;
      round_irq <= 1'b0;
    end else begin
      data_irq  <= op_valid && data_c;
      round_irq <= op_valid && round_c;
    end
  end

  default clocking cb_clk @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  no_special_out_a: assert property (
    res_valid |-> (efp_exp(dbl_reg, res_value) != (dbl_reg ? EALL_D : EALL_S)))
    else $error("infinity or NaN delivered");
  no_denorm_out_a: assert property (
    res_valid && efp_exp(dbl_reg, res_value) == 11'h0 |->
    (dbl_reg ? res_value[51:0] == 52'h0 : res_value[22:0] == 23'h0))
    else $error("denormal delivered");
  ovf_saturate_a: assert property (
    res_valid && res_ovf |-> res_value == efp_sat(dbl_reg, efp_sign(dbl_reg, res_value)))
    else $error("overflow result not saturated");
  ovf_inexact_a: assert property (
    op_valid && ovf && !ctrl[C_OVFE] |=> res_inexact && u_regs.sticky_reg[S_INX])
    else $error("overflow without inexact");
  unf_zero_a: assert property (
    op_valid && unf && !ctrl[C_UNFE] |=> res_inexact && (efp_exp(dbl_reg, res_value) == 11'h0))
    else $error("underflow not flushed to zero");
  round_irq_a: assert property (
    op_valid && inexact && ctrl[C_INXE] && !data_c |=>
    round_irq && !data_irq ##1 (!round_irq || $past(op_valid)))
    else $error("round interrupt missing");
  divzero_irq_a: assert property (
    op_valid && dbz && ctrl[C_DBZE] |=> data_irq && u_regs.sticky_reg[S_DBZ])
    else $error("divide by zero interrupt missing");
  irq_cause_a: assert property (
    data_irq |-> $past(op_valid) && !round_irq)
    else $error("data interrupt without cause");
  zero_sum_sign_a: assert property (
    op_valid && addsub && core_zero && !invalid && ctrl[C_RND+:2] == RND_NEG |=>
    efp_sign(dbl_reg, res_value))
    else $error("zero sum not negative when rounding down");
  est_ovf_a: assert property (
    op_valid && ctrl[C_EST] && op_code == OP_ADD && !invalid && !core_zero &&
    ca.exp == 11'h0fe && !op_dbl |=> res_ovf)
    else $error("exponent estimate missed overflow");
  mode_zero_a: assert property (
    ctrl[C_MODE] == 1'b0)
    else $error("undefined mode accepted");

  ovf_seen_c: cover property (op_valid && ovf ##1 data_irq);
  unf_seen_c: cover property (op_valid && unf && !ctrl[C_UNFE]);
  dbz_seen_c: cover property (op_valid && dbz);
  negzero_c: cover property (op_valid && addsub && core_zero && r_sign);
endmodule
